/* File: hw/ccrc_ctrl.sv */
// The AHB-Lite interface to the registers was left to the implementer.
`include "ccrc_params.svh"
`default_nettype none
module ccrc_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire ccrc_pkg::ccrc_word_t haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire ccrc_pkg::ccrc_word_t hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var ccrc_pkg::ccrc_word_t hrdata,
	output var logic hresp,
	input wire logic ext_reset,
	input wire logic bus_off_event,
	input wire logic bus_free_pulse,
	input wire logic bus_activity,
	input wire logic irq_pending,
	input wire logic tx_in_progress,
	input wire logic tx_success,
	input wire logic overrun_event,
	output var logic hold_in_reset,
	output var logic bus_on,
	output var logic reference_drive_select,
	output var logic edge_sync_both,
	output var logic send_request,
	output var logic abort_send_cmd,
	output var logic free_receive_slot_cmd,
	output var logic sleeping,
	output var logic wake_irq,
	output var logic rx_enable,
	output var logic wake_source_select,
	output var logic first_from_reference,
	output var logic second_from_reference,
	output var logic send_done_flag,
	output var logic send_buffer_free_flag,
	output var logic overrun_flag,
	output logic [39:0] timing_config
);
	import ccrc_pkg::*;

	// ==========================================================
	// state
	ccrc_join_t join_state;
	logic cause_busoff;
	logic [6:0] free_cnt;
	logic sleep_request;
	logic [1:0] switch_bits;
	ccrc_byte_t timing_cfg [0:4];
	logic rd_phase;
	logic wr_phase;
	ccrc_idx_t rd_idx;
	ccrc_idx_t wr_idx;
	logic take;
	logic wr_ctl;
	logic wr_cmd;
	logic wr_tim;
	logic cmd_send;
	logic cmd_abort;
	logic cmd_free;
	logic cmd_clrovr;
	logic enter_sleep;
	logic leave_sleep;
	logic force_hold;

	function automatic ccrc_idx_t reg_index(input ccrc_word_t a);
		if (a[31:8] == 24'h000000 && a[1:0] == 2'h0)
			return a[7:2];
		return `CCRC_IDX_UNMAPPED;
	endfunction

	function automatic logic in_timing(input ccrc_idx_t i);
		return i >= `CCRC_IDX_TIMING_LO && i <= `CCRC_IDX_TIMING_HI;
	endfunction

	function automatic ccrc_word_t read_mux(input ccrc_idx_t i);
		ccrc_word_t d;
		d = 32'h00000000;
		if (i == `CCRC_IDX_CONTROL) begin
			d[`CCRC_CTL_HOLD] = hold_in_reset;
			d[`CCRC_CTL_REF] = reference_drive_select;
			d[`CCRC_CTL_SYNC] = edge_sync_both;
		end else if (i == `CCRC_IDX_COMMAND) begin
			d[3:0] = `CCRC_CMD_PULSE_READ;
			d[`CCRC_CMD_SLEEP] = sleeping;
			d[`CCRC_CMD_WAKESEL] = wake_source_select;
			d[`CCRC_CMD_SW0] = switch_bits[1];
			d[`CCRC_CMD_SW1] = switch_bits[0];
		end else if (in_timing(i) && hold_in_reset) begin
			d[7:0] = timing_cfg[3'(i - `CCRC_IDX_TIMING_LO)];
		end else if (i == `CCRC_IDX_STATE) begin
			d[7:0] = {cause_busoff, rx_enable, overrun_flag,
				send_buffer_free_flag, send_done_flag, send_request,
				sleeping, bus_on};
		end
		return d;
	endfunction

	// ==========================================================
	// bus slave: writes zero-wait, reads one wait state
	assign take = ce && hsel && htrans[1] && hready;
	assign wr_ctl = wr_phase && wr_idx == `CCRC_IDX_CONTROL;
	assign wr_cmd = wr_phase && wr_idx == `CCRC_IDX_COMMAND;
	assign wr_tim = wr_phase && in_timing(wr_idx) && hold_in_reset;
	assign cmd_send = wr_cmd && hwdata[`CCRC_CMD_SEND];
	assign cmd_abort = wr_cmd && hwdata[`CCRC_CMD_ABORT];
	assign cmd_free = wr_cmd && hwdata[`CCRC_CMD_FREE];
	assign cmd_clrovr = wr_cmd && hwdata[`CCRC_CMD_CLROVR];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_phase <= 1'b0;
			wr_phase <= 1'b0;
			rd_idx <= `CCRC_IDX_UNMAPPED;
			wr_idx <= `CCRC_IDX_UNMAPPED;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else if (ce) begin
			rd_phase <= take && !hwrite;
			wr_phase <= take && hwrite;
			hreadyout <= !(take && !hwrite);
			if (take)
				rd_idx <= reg_index(haddr);
			if (take)
				wr_idx <= reg_index(haddr);
			if (rd_phase)
				hrdata <= read_mux(rd_idx);
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// reset request and rejoin
	assign force_hold = ext_reset || bus_off_event;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_in_reset <= 1'b1;
			cause_busoff <= 1'b0;
		end else if (ce) begin
			if (force_hold) begin
				hold_in_reset <= 1'b1;
			end else if (wr_ctl) begin
				hold_in_reset <= hwdata[`CCRC_CTL_HOLD];
			end
			if (ext_reset) begin
				cause_busoff <= 1'b0;
			end else if (bus_off_event) begin
				cause_busoff <= 1'b1;
			end else if (wr_ctl && hwdata[`CCRC_CTL_HOLD] && !hold_in_reset) begin
				cause_busoff <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			join_state <= JOIN_HELD;
			free_cnt <= 7'h00;
		end else if (ce) begin
			unique case (join_state)
				JOIN_HELD: begin
					free_cnt <= 7'h00;
					if (!hold_in_reset)
						join_state <= JOIN_WAIT;
				end
				JOIN_WAIT: begin
					if (hold_in_reset) begin
						join_state <= JOIN_HELD;
					end else if (bus_free_pulse) begin
						if (free_cnt == (cause_busoff ? `CCRC_FREE_AFTER_BUSOFF
							: `CCRC_FREE_AFTER_CPU))
							join_state <= JOIN_ON;
						else
							free_cnt <= free_cnt + 7'h01;
					end
				end
				JOIN_ON: begin
					if (hold_in_reset)
						join_state <= JOIN_HELD;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			bus_on <= 1'b0;
		else if (ce)
			bus_on <= join_state == JOIN_ON && !hold_in_reset && !force_hold;
	end

	// ==========================================================
	// configuration guarded by hold-in-reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reference_drive_select <= `CCRC_RST_REF;
			edge_sync_both <= `CCRC_RST_SYNC;
		end else if (ce) begin
			if (ext_reset) begin
				reference_drive_select <= `CCRC_RST_REF;
			end else if (wr_ctl && hold_in_reset) begin
				reference_drive_select <= hwdata[`CCRC_CTL_REF];
				edge_sync_both <= hwdata[`CCRC_CTL_SYNC];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < 5; k++)
				timing_cfg[k] <= 8'h00;
		end else if (ce && wr_tim) begin
			timing_cfg[3'(wr_idx - `CCRC_IDX_TIMING_LO)] <= hwdata[7:0];
		end
	end

	assign timing_config = {timing_cfg[4], timing_cfg[3], timing_cfg[2],
		timing_cfg[1], timing_cfg[0]};

	// ==========================================================
	// comparator routing and wake source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			switch_bits <= `CCRC_RST_SWITCH;
			first_from_reference <= 1'b0;
			second_from_reference <= 1'b0;
			wake_source_select <= 1'b0;
		end else if (ce && wr_cmd) begin
			switch_bits <= {hwdata[`CCRC_CMD_SW0], hwdata[`CCRC_CMD_SW1]};
			wake_source_select <= hwdata[`CCRC_CMD_WAKESEL];
			if (hwdata[`CCRC_CMD_SW0] || hwdata[`CCRC_CMD_SW1]) begin
				first_from_reference <= !hwdata[`CCRC_CMD_SW0];
				second_from_reference <= !hwdata[`CCRC_CMD_SW1];
			end
		end
	end

	// ==========================================================
	// sleep and wake
	assign enter_sleep = !sleeping && sleep_request && !irq_pending
		&& !bus_activity;
	assign leave_sleep = sleeping && (!sleep_request || bus_activity);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_request <= 1'b0;
			sleeping <= 1'b0;
			wake_irq <= 1'b0;
			rx_enable <= 1'b1;
		end else if (ce) begin
			wake_irq <= leave_sleep;
			if (wr_cmd)
				sleep_request <= hwdata[`CCRC_CMD_SLEEP];
			else if (leave_sleep && bus_activity)
				sleep_request <= 1'b0;
			if (enter_sleep)
				sleeping <= 1'b1;
			else if (leave_sleep)
				sleeping <= 1'b0;
			if (leave_sleep && bus_activity)
				rx_enable <= 1'b0;
			else if (bus_free_pulse)
				rx_enable <= 1'b1;
		end
	end

	// ==========================================================
	// send, abort, receive release, overrun
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			send_request <= 1'b0;
			send_done_flag <= `CCRC_RST_SEND_DONE;
			send_buffer_free_flag <= `CCRC_RST_BUF_FREE;
			abort_send_cmd <= 1'b0;
		end else if (ce) begin
			abort_send_cmd <= cmd_abort;
			if (cmd_send) begin
				send_request <= 1'b1;
				send_done_flag <= 1'b0;
				send_buffer_free_flag <= 1'b0;
			end else if (tx_success && send_request) begin
				send_request <= 1'b0;
				send_done_flag <= 1'b1;
				send_buffer_free_flag <= 1'b1;
			end else if (cmd_abort && send_request && !tx_in_progress) begin
				send_request <= 1'b0;
				send_buffer_free_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_flag <= 1'b0;
			free_receive_slot_cmd <= 1'b0;
		end else if (ce) begin
			free_receive_slot_cmd <= cmd_free;
			if (overrun_event)
				overrun_flag <= 1'b1;
			else if (cmd_clrovr)
				overrun_flag <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	default clocking ast_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_activity_wake;
		ce && sleeping && bus_activity && !bus_free_pulse;
	endsequence

	sequence s_cmd_read;
		ce && rd_phase && rd_idx == `CCRC_IDX_COMMAND;
	endsequence

	AST_HOLD_FORCED: assert property (ce && force_hold |=>
		hold_in_reset && !bus_on) else $error("reset request not forced");
	AST_REF_GUARD: assert property ($changed(reference_drive_select)
		|-> $past(hold_in_reset) || $past(ext_reset))
		else $error("reference drive changed outside reset request");
	AST_SYNC_GUARD: assert property ($changed(edge_sync_both) |->
		$past(hold_in_reset) && $past(wr_ctl))
		else $error("edge sync changed outside reset request");
	AST_CMD_ONES: assert property (s_cmd_read |=> hrdata[3:0] == 4'hf
		&& hreadyout) else $error("command read low nibble not ones");
	AST_JOIN_ONE: assert property (ce && join_state == JOIN_WAIT
		&& !cause_busoff && bus_free_pulse && !hold_in_reset |=>
		join_state == JOIN_ON) else $error("no rejoin after one bus-free");
	AST_JOIN_128: assert property (ce && join_state == JOIN_WAIT
		&& cause_busoff && free_cnt < `CCRC_FREE_AFTER_BUSOFF |=>
		join_state != JOIN_ON) else $error("rejoin before 128 bus-free");
	AST_SLEEP_ENTRY: assert property ($rose(sleeping) |->
		$past(sleep_request && !irq_pending && !bus_activity))
		else $error("sleep entered with activity or interrupt");
	AST_WAKE_IRQ: assert property ($fell(sleeping) |-> wake_irq
		##1 !wake_irq || !ce) else $error("wake without wake interrupt");
	AST_RX_BLOCKED: assert property (s_activity_wake |=>
		!rx_enable until (ce && bus_free_pulse))
		else $error("reception resumed before bus-free");
	AST_OVR_CLEAR: assert property (ce && cmd_clrovr
		&& !overrun_event |=> !overrun_flag) else $error("overrun not cleared");
	AST_SEND_KEPT: assert property (ce && send_request && !cmd_abort
		&& !tx_success |=> send_request)
		else $error("send request dropped without abort");
	AST_ABORT_FREE: assert property (ce && cmd_abort && !cmd_send
		&& send_request && !tx_in_progress && !tx_success |=>
		!send_request && send_buffer_free_flag && !send_done_flag)
		else $error("abort did not cancel and free buffer");
	AST_RUNNING_KEPT: assert property (ce && cmd_abort && !cmd_send
		&& send_request && tx_in_progress && !tx_success |=> send_request)
		else $error("running send stopped by abort");
	AST_SEND_CLEARS_DONE: assert property (ce && cmd_send |=>
		!send_done_flag && send_request && !send_buffer_free_flag)
		else $error("send request did not clear send-done");
	AST_FREE_PULSE: assert property (ce && cmd_free |=>
		free_receive_slot_cmd) else $error("receive slot not freed");
	AST_ROUTE: assert property (ce && wr_cmd && hwdata[7:6] == 2'h1 |=>
		first_from_reference && !second_from_reference)
		else $error("comparator routing wrong");
endmodule
`default_nettype wire

/* File: hw/ccrc_params.svh */
`ifndef CCRC_PARAMS_SVH
`define CCRC_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define CCRC_IDX_CONTROL 6'h00
`define CCRC_IDX_COMMAND 6'h01
`define CCRC_IDX_TIMING_LO 6'h04
`define CCRC_IDX_TIMING_HI 6'h08
`define CCRC_IDX_STATE 6'h20
`define CCRC_IDX_UNMAPPED 6'h3f

// ==========================================================
// field positions
`define CCRC_CTL_HOLD 0
`define CCRC_CTL_REF 5
`define CCRC_CTL_SYNC 6
`define CCRC_CMD_SEND 0
`define CCRC_CMD_ABORT 1
`define CCRC_CMD_FREE 2
`define CCRC_CMD_CLROVR 3
`define CCRC_CMD_SLEEP 4
`define CCRC_CMD_WAKESEL 5
`define CCRC_CMD_SW1 6
`define CCRC_CMD_SW0 7
`define CCRC_CMD_PULSE_READ 4'hf

// ==========================================================
// reset values and counts
`define CCRC_RST_REF 1'b1
`define CCRC_RST_SYNC 1'b0
`define CCRC_RST_SWITCH 2'h3
`define CCRC_RST_SEND_DONE 1'b1
`define CCRC_RST_BUF_FREE 1'b1
`define CCRC_FREE_AFTER_CPU 7'h00
`define CCRC_FREE_AFTER_BUSOFF 7'h7f

`endif

/* File: hw/ccrc_pkg.sv */
`default_nettype none
package ccrc_pkg;
	typedef logic [31:0] ccrc_word_t;
	typedef logic [7:0] ccrc_byte_t;
	typedef logic [5:0] ccrc_idx_t;
	typedef enum logic [2:0] {
		JOIN_HELD = 3'h1,
		JOIN_WAIT = 3'h2,
		JOIN_ON = 3'h4
	} ccrc_join_t;
endpackage
`default_nettype wire

/* File: sim/ccrc_engine_model.sv */
`default_nettype none
module ccrc_engine_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic send_request,
	input wire logic start_ok,
	input wire logic bus_busy,
	output logic bus_free_pulse,
	output logic bus_activity,
	output logic tx_in_progress,
	output logic tx_success
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] idle;
	logic [4:0] txc;
	assign bus_activity = bus_busy | tx_in_progress;
	// ==========
	// bus free after 11 idle bit times
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle <= 5'h00;
			bus_free_pulse <= 1'b0;
		end else begin
			bus_free_pulse <= !bus_activity && idle == 5'h0a;
			idle <= (bus_activity || idle == 5'h0b) ? 5'h00 : idle + 5'h01;
		end
	end
	// ==========
	// frame starts when allowed, lasts 20 cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_in_progress <= 1'b0;
			tx_success <= 1'b0;
			txc <= 5'h00;
		end else begin
			tx_success <= tx_in_progress && txc == 5'h13;
			txc <= tx_in_progress ? txc + 5'h01 : 5'h00;
			if (tx_in_progress && txc == 5'h13)
				tx_in_progress <= 1'b0;
			else if (send_request && start_ok && !tx_success)
				tx_in_progress <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: sim/can_command_and_reset_control_tb.sv */
`include "ccrc_params.svh"
`default_nettype none
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
`define WAITC(c) begin w = 0; #1; while (!(c) && w < 3000) begin \
	@(posedge hclk); #1; w++; end `CHK("wait", 1, c); end
module can_command_and_reset_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccrc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, ext_reset = 1'b0;
	logic bus_off_event = 1'b0, irq_pending = 1'b0, overrun_event = 1'b0;
	logic start_ok = 1'b0, bus_busy = 1'b0, rdy_n;
	logic [1:0] htrans = 2'h0;
	ccrc_word_t haddr = 32'h0, hwdata = 32'h0, hrdata;
	ccrc_byte_t rd_n, d;
	logic hreadyout, hold_in_reset, bus_on, reference_drive_select;
	logic edge_sync_both, send_request, abort_send_cmd, sleeping, wake_irq;
	logic free_receive_slot_cmd, rx_enable, wake_source_select;
	logic first_from_reference, second_from_reference, send_done_flag;
	logic send_buffer_free_flag, overrun_flag, bus_free_pulse, bus_activity;
	logic tx_in_progress, tx_success;
	logic hresp;
	logic [39:0] timing_config;
	int n_fail = 0, n_checks = 0, w, b, n_bf = 0, n_wake = 0, n_rel = 0;
	logic [1:0] exp_rt [4] = '{2'h2, 2'h2, 2'h1, 2'h0};

	ccrc_ctrl u_dut (.hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .ext_reset, .bus_off_event,
		.bus_free_pulse, .bus_activity, .irq_pending, .tx_in_progress,
		.tx_success, .overrun_event, .hold_in_reset, .bus_on,
		.reference_drive_select, .edge_sync_both, .send_request,
		.abort_send_cmd, .free_receive_slot_cmd, .sleeping, .wake_irq,
		.rx_enable, .wake_source_select, .first_from_reference,
		.second_from_reference, .send_done_flag, .send_buffer_free_flag,
		.overrun_flag, .timing_config);
	ccrc_engine_model u_model (.hclk, .hresetn, .send_request, .start_ok,
		.bus_busy, .bus_free_pulse, .bus_activity, .tx_in_progress,
		.tx_success);

	initial forever #4 hclk = ~hclk;
	// settled copies, taken away from the sampling edge
	always @(negedge hclk) begin
		rdy_n = hreadyout;
		rd_n = hrdata[7:0];
		n_bf += bus_free_pulse;
		n_wake += wake_irq;
		n_rel += free_receive_slot_cmd;
	end

	task automatic chk(string n, ccrc_byte_t e, ccrc_byte_t g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic xfer(ccrc_idx_t i, logic wr_en, ccrc_byte_t v);
		haddr <= {24'h0, i, 2'b00};
		htrans <= 2'h2;
		hwrite <= wr_en;
		do @(posedge hclk); while (!rdy_n);
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		do @(posedge hclk); while (!rdy_n);
		d = rd_n;
	endtask
	task automatic wr(ccrc_idx_t i, ccrc_byte_t v);
		xfer(i, 1'b1, v);
	endtask
	task automatic rd(ccrc_idx_t i);
		xfer(i, 1'b0, 8'h00);
	endtask
	task automatic te(string s);
		$display("test %s done", s);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		test_done;
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`CCRC_IDX_CONTROL);
		`CHK("ctrl", 8'h21, d);
		rd(`CCRC_IDX_COMMAND);
		`CHK("cmd", 8'hcf, d);
		rd(`CCRC_IDX_STATE);
		`CHK("state", 8'h58, d);
		rd(`CCRC_IDX_UNMAPPED);
		`CHK("unmapped", 8'h00, d);
		te("reset");
		// ==========
		wr(`CCRC_IDX_TIMING_LO, 8'h5a);
		rd(`CCRC_IDX_TIMING_LO);
		`CHK("timing held", 8'h5a, d);
		`CHK("timing out", 8'h5a, timing_config[7:0]);
		wr(`CCRC_IDX_CONTROL, 8'h41);
		rd(`CCRC_IDX_CONTROL);
		`CHK("ctrl held", 8'h41, d);
		`CHK("sync out", 1, edge_sync_both);
		wr(`CCRC_IDX_CONTROL, 8'h20);
		b = n_bf;
		`WAITC(bus_on)
		`CHK("free count cpu", 1, n_bf - b);
		rd(`CCRC_IDX_CONTROL);
		`CHK("ctrl release", 8'h20, d);
		rd(`CCRC_IDX_TIMING_LO);
		`CHK("timing run", 8'h00, d);
		`CHK("resp", 0, hresp);
		wr(`CCRC_IDX_CONTROL, 8'h40);
		rd(`CCRC_IDX_CONTROL);
		`CHK("ctrl locked", 8'h20, d);
		te("hold");
		// ==========
		bus_off_event <= 1'b1;
		@(posedge hclk);
		bus_off_event <= 1'b0;
		@(posedge hclk);
		#1;
		`CHK("bus off", 2'h2, {hold_in_reset, bus_on});
		wr(`CCRC_IDX_CONTROL, 8'h20);
		b = n_bf;
		`WAITC(bus_on)
		`CHK("free count off", 128, n_bf - b);
		wr(`CCRC_IDX_CONTROL, 8'h01);
		wr(`CCRC_IDX_CONTROL, 8'h01);
		ext_reset <= 1'b1;
		@(posedge hclk);
		ext_reset <= 1'b0;
		rd(`CCRC_IDX_CONTROL);
		`CHK("pin reset", 8'h21, d);
		`CHK("ref out", 1, reference_drive_select);
		te("rejoin");
		// ==========
		for (int i = 3; i >= 0; i--) begin
			wr(`CCRC_IDX_COMMAND, {i[1:0], 6'h00});
			#1;
			`CHK("route", exp_rt[i], {first_from_reference,
				second_from_reference});
			rd(`CCRC_IDX_COMMAND);
			`CHK("switch read", {i[1:0], 6'h0f}, d);
		end
		wr(`CCRC_IDX_COMMAND, 8'hc0);
		wr(`CCRC_IDX_CONTROL, 8'h20);
		te("switches");
		// ==========
		wr(`CCRC_IDX_COMMAND, 8'hc1);
		#1;
		`CHK("queued", 3'h4, {send_request, send_done_flag,
			send_buffer_free_flag});
		wr(`CCRC_IDX_COMMAND, 8'hc0);
		#1;
		`CHK("zero keeps", 3'h4, {send_request, send_done_flag,
			send_buffer_free_flag});
		wr(`CCRC_IDX_COMMAND, 8'hc2);
		#1;
		`CHK("abort pulse", 1, abort_send_cmd);
		`CHK("aborted", 3'h1, {send_request, send_done_flag,
			send_buffer_free_flag});
		@(posedge hclk);
		#1;
		`CHK("abort ends", 0, abort_send_cmd);
		start_ok <= 1'b1;
		wr(`CCRC_IDX_COMMAND, 8'hc1);
		`WAITC(tx_in_progress)
		wr(`CCRC_IDX_COMMAND, 8'hc2);
		#1;
		`CHK("running kept", 1, send_request);
		`WAITC(send_buffer_free_flag)
		`CHK("sent", 3'h3, {send_request, send_done_flag,
			send_buffer_free_flag});
		start_ok <= 1'b0;
		te("send");
		// ==========
		irq_pending <= 1'b1;
		wr(`CCRC_IDX_COMMAND, 8'hf0);
		repeat (4) @(posedge hclk);
		#1;
		`CHK("no sleep irq", 0, sleeping);
		`CHK("wake single", 1, wake_source_select);
		irq_pending <= 1'b0;
		`WAITC(sleeping)
		rd(`CCRC_IDX_COMMAND);
		`CHK("sleep read", 8'hff, d);
		b = n_wake;
		wr(`CCRC_IDX_COMMAND, 8'hc0);
		`WAITC(!sleeping)
		@(negedge hclk);
		#1;
		`CHK("cpu wake", 1, n_wake - b);
		wr(`CCRC_IDX_COMMAND, 8'hd0);
		`WAITC(sleeping)
		`CHK("wake diff", 0, wake_source_select);
		bus_busy <= 1'b1;
		`WAITC(!sleeping)
		@(negedge hclk);
		#1;
		`CHK("bus wake", 2, n_wake - b);
		`CHK("rx blocked", 0, rx_enable);
		rd(`CCRC_IDX_COMMAND);
		`CHK("awake read", 8'hcf, d);
		bus_busy <= 1'b0;
		b = n_bf;
		`WAITC(rx_enable)
		@(negedge hclk);
		#1;
		`CHK("rx after free", 1, n_bf - b);
		te("sleep");
		// ==========
		@(posedge hclk);
		overrun_event <= 1'b1;
		@(posedge hclk);
		overrun_event <= 1'b0;
		b = n_rel;
		wr(`CCRC_IDX_COMMAND, 8'hc4);
		repeat (3) @(posedge hclk);
		#1;
		`CHK("overrun kept", 1, overrun_flag);
		wr(`CCRC_IDX_COMMAND, 8'hcc);
		#1;
		`CHK("overrun clear", 0, overrun_flag);
		@(negedge hclk);
		#1;
		`CHK("releases", 2, n_rel - b);
		te("receive");
		test_done;
	end
endmodule
`default_nettype wire
